// ==== hw/iic_master_pkg.sv ====
// Package with register map, field positions and reset values of the block.
package iic_master_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] OFF_CTRL1 = 8'h00;
   localparam logic [7:0] OFF_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_TIMING = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_CLEAR = 8'h10;
   localparam logic [7:0] OFF_RXDATA = 8'h14;
   localparam logic [7:0] OFF_TXDATA = 8'h18;
   localparam logic [7:0] OFF_CLKGATE = 8'h40;
   localparam logic [7:0] OFF_PINSEL = 8'h44;
   // ****************************************************************
   // Reset values and write masks
   // ****************************************************************
   localparam logic [31:0] RST_CTRL1 = 32'h0000_0000;
   localparam logic [31:0] RST_CTRL2 = 32'h1000_0000;
   localparam logic [31:0] RST_TIMING = 32'h0000_0000;
   localparam logic [31:0] RST_CLKGATE = 32'h0000_0001;
   localparam logic [31:0] MASK_CTRL1 = 32'h0000_20f7;
   localparam logic [31:0] MASK_CTRL2 = 32'h1bff_64fe;
   localparam logic [31:0] MASK_CLKGATE = 32'h00ff_ff00;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CR1_UNIT_ON = 0;
   localparam int CR1_TX_IE = 1;
   localparam int CR1_RX_IE = 2;
   localparam int CR1_NACK_IE = 4;
   localparam int CR1_STOP_IE = 5;
   localparam int CR1_DONE_IE = 6;
   localparam int CR1_ERR_IE = 7;
   localparam int CR1_SLEW = 13;
   localparam int CR2_RD_WRN = 10;
   localparam int CR2_START = 13;
   localparam int CR2_STOP = 14;
   localparam int CR2_NBYTES_LO = 16;
   localparam int CR2_RELOAD = 24;
   localparam int CR2_AUTOEND = 25;
   localparam int GATE_BUS_UNIT = 8;
   localparam int GATE_PIN_UNIT = 22;
   localparam int PINSEL_ALT = 0;
   localparam int ST_TXE = 0;
   localparam int ST_TRANSMIT_REQUEST_FLAG = 1;
   localparam int ST_RECEIVE_FULL_FLAG = 2;
   localparam int ST_NACK = 4;
   localparam int ST_STOP = 5;
   localparam int ST_TC = 6;
   localparam int ST_TCR = 7;
   localparam int ST_BUS_ERROR_FLAG = 8;
   localparam int ST_ARBITRATION_LOST_FLAG = 9;
   localparam int ST_BUSY = 15;
   // Event lanes crossing from the link clock.
   localparam int EV_FALL8 = 0;
   localparam int EV_FALL9 = 1;
   localparam int EV_NACK = 2;
   localparam int EV_STOP = 3;
   localparam int EV_ARB = 4;
   localparam int EV_BUS_ERROR_FLAG = 5;
   localparam int EV_COUNT = 6;
endpackage

// ==== hw/iic_master_control_regs.sv ====
// Control registers, flag logic and link event crossing of the bus master.
// ********************************************************************
// Summary of operation
// - Registers decode at 0x00 to 0x18 in steps of four, then at 0x40 and 0x44.
// - The bus unit runs only while clock gate bit 8 is one, zero at reset.
// - The pin unit runs only while clock gate bit 22 is one, zero at reset.
// - The clock gate register resets to one and bits 8 to 23 are RW.
// - Control 1 bit 13 turns slew limiting on for standard speed.
// - Bit 7 lets arbitration loss or bus error raise the interrupt.
// - Bit 6 lets transfer complete or reload wait raise the interrupt.
// - Bit 5 lets the stop detected flag raise the interrupt.
// - Bit 4 lets the refused acknowledge flag raise the interrupt.
// - Bit 2 lets the receive full flag raise the interrupt.
// - Bit 1 lets the transmit request flag raise the interrupt.
// - Control 1 resets to zero and its reserved bits read zero.
// - Clearing unit on releases the lines and clears requests and flags.
// - Transmit request rises at the ninth fall when writing, unless last without reload.
// - Receive full rises at the eighth fall when reading, refused ack at the ninth.
// - Pin select bit 0 moves clock and data to the alternate pins.
// ********************************************************************
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none

// ********************************************************************
// Event crossing
// ********************************************************************
module event_crossing #(
   parameter int N = 1
) (
   // Link side.
   input wire logic link_clk,
   input wire logic [N-1:0] link_pulse,
   // System side.
   input wire logic pclk,
   input wire logic presetn,
   output logic [N-1:0] sys_pulse
);
   logic [N-1:0] toggle_reg;
   logic [N-1:0] sync1_reg;
   logic [N-1:0] sync2_reg;
   logic [N-1:0] sync3_reg;
   logic [N-1:0] seen_reg;

   // Each pulse flips a level, so no event is lost at slow sampling.
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         toggle_reg <= '0;
      end else begin
         toggle_reg <= toggle_reg ^ link_pulse;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         seen_reg <= '0;
      end else begin
         sync1_reg <= toggle_reg;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         seen_reg <= (sync2_reg & sync3_reg) | (seen_reg & (sync2_reg | sync3_reg));
      end
   end

   // A change counts once the second and third stages agree.
   assign sys_pulse = (sync2_reg & sync3_reg & ~seen_reg) |
                      (~sync2_reg & ~sync3_reg & seen_reg);
endmodule // event_crossing

// ********************************************************************
// Top module
// ********************************************************************
module iic_master_control_regs (
   // System clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link clock and serial engine events.
   input wire logic link_clk,
   input wire logic ev_fall8,
   input wire logic ev_fall9,
   input wire logic ev_nack,
   input wire logic ev_stop,
   input wire logic ev_arb_lost,
   input wire logic ev_bus_error,
   input wire logic [7:0] rx_byte,
   // Engine control, system clock domain.
   output logic bus_unit_clock_gate,
   output logic pin_unit_clock_gate,
   output logic slew_limit_select,
   output logic alt_pin_select,
   output logic engine_release,
   output logic start_request,
   output logic stop_request,
   output logic [7:0] tx_byte,
   // Interrupt request.
   output logic irq
);
   logic [31:0] ctrl1_reg;
   logic [31:0] ctrl2_reg;
   logic [31:0] timing_reg;
   logic [31:0] clkgate_reg;
   logic pinsel_reg;
   logic [7:0] txdata_reg;
   logic [7:0] rxdata_reg;
   logic [7:0] rx_hold_reg;
   logic [7:0] byte_cnt_reg;
   logic [15:0] status_reg;
   logic [15:0] status_next;
   localparam int EV_COUNT_W = iic_master_pkg::EV_COUNT;
   logic [31:0] rdata_next;
   logic hit_next;
   logic setup_phase;
   logic wr_done;
   logic rd_done;
   logic [EV_COUNT_W-1:0] link_ev;
   logic [EV_COUNT_W-1:0] sys_ev;
   logic active;
   logic last_byte;
   logic unit_on;

   assign setup_phase = psel & ~penable;
   assign wr_done = psel & penable & pready & pwrite;
   assign rd_done = psel & penable & pready & ~pwrite;
   assign unit_on = ctrl1_reg[iic_master_pkg::CR1_UNIT_ON];

   // ****************************************************************
   // Link side capture and crossing
   // ****************************************************************
   // The byte is held until the next eighth fall, far longer than
   // the crossing delay, so the system side samples a stable value.
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         rx_hold_reg <= 8'h00;
      end else if (ev_fall8) begin
         rx_hold_reg <= rx_byte;
      end
   end

   assign link_ev = {ev_bus_error, ev_arb_lost, ev_stop, ev_nack,
                     ev_fall9, ev_fall8};

   event_crossing #(
      .N(EV_COUNT_W)
   ) u_events (
      .link_clk(link_clk),
      .link_pulse(link_ev),
      .pclk(pclk),
      .presetn(presetn),
      .sys_pulse(sys_ev)
   );

   // Events count only while the unit is clocked and switched on.
   assign active = clkgate_reg[iic_master_pkg::GATE_BUS_UNIT] & unit_on;

   // ****************************************************************
   // APB read decode
   // ****************************************************************
   always_comb begin
      rdata_next = 32'h0000_0000;
      hit_next = 1'b1;
      case (paddr)
         iic_master_pkg::OFF_CTRL1: rdata_next = ctrl1_reg;
         iic_master_pkg::OFF_CTRL2: rdata_next = ctrl2_reg;
         iic_master_pkg::OFF_TIMING: rdata_next = timing_reg;
         iic_master_pkg::OFF_STATUS: rdata_next = {16'h0000, status_reg};
         iic_master_pkg::OFF_CLEAR: rdata_next = 32'h0000_0000;
         iic_master_pkg::OFF_RXDATA: rdata_next = {24'h000000, rxdata_reg};
         iic_master_pkg::OFF_TXDATA: rdata_next = {24'h000000, txdata_reg};
         iic_master_pkg::OFF_CLKGATE: rdata_next = clkgate_reg;
         iic_master_pkg::OFF_PINSEL: rdata_next = {31'h0, pinsel_reg};
         default: hit_next = 1'b0;
      endcase
   end

   // No wait state, and every bus output still comes straight from a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~hit_next;
         prdata <= setup_phase ? rdata_next : 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_reg <= iic_master_pkg::RST_CTRL1;
         timing_reg <= iic_master_pkg::RST_TIMING;
         clkgate_reg <= iic_master_pkg::RST_CLKGATE;
         pinsel_reg <= 1'b0;
      end else if (wr_done) begin
         if (paddr == iic_master_pkg::OFF_CTRL1) begin
            ctrl1_reg <= pwdata & iic_master_pkg::MASK_CTRL1;
         end
         if (paddr == iic_master_pkg::OFF_TIMING) begin
            timing_reg <= pwdata;
         end
         if (paddr == iic_master_pkg::OFF_CLKGATE) begin
            clkgate_reg <= (pwdata & iic_master_pkg::MASK_CLKGATE) |
                           iic_master_pkg::RST_CLKGATE;
         end
         if (paddr == iic_master_pkg::OFF_PINSEL) begin
            pinsel_reg <= pwdata[iic_master_pkg::PINSEL_ALT];
         end
      end
   end

   // Start and stop are set by software only, cleared by hardware.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl2_reg <= iic_master_pkg::RST_CTRL2;
      end else begin
         if (wr_done && paddr == iic_master_pkg::OFF_CTRL2) begin
            // Requests cannot be raised while the unit is off.
            ctrl2_reg <= ((pwdata & iic_master_pkg::MASK_CTRL2) |
                          (ctrl2_reg & 32'h0000_6000) |
                          (iic_master_pkg::RST_CTRL2 &
                           ~iic_master_pkg::MASK_CTRL2)) &
                         ~({32{~unit_on}} & 32'h0000_6000);
         end else begin
            if (!unit_on || (active && (sys_ev[iic_master_pkg::EV_STOP] ||
                sys_ev[iic_master_pkg::EV_ARB]))) begin
               ctrl2_reg[iic_master_pkg::CR2_START] <= 1'b0;
            end
            if (!unit_on || (active && sys_ev[iic_master_pkg::EV_STOP])) begin
               ctrl2_reg[iic_master_pkg::CR2_STOP] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txdata_reg <= 8'h00;
         rxdata_reg <= 8'h00;
      end else begin
         if (wr_done && paddr == iic_master_pkg::OFF_TXDATA) begin
            txdata_reg <= pwdata[7:0];
         end
         if (active && sys_ev[iic_master_pkg::EV_FALL8] &&
             ctrl2_reg[iic_master_pkg::CR2_RD_WRN]) begin
            rxdata_reg <= rx_hold_reg;
         end
      end
   end

   // ****************************************************************
   // Byte counting and status flags
   // ****************************************************************
   assign last_byte = (byte_cnt_reg + 8'h01) ==
                      ctrl2_reg[iic_master_pkg::CR2_NBYTES_LO +: 8];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_cnt_reg <= 8'h00;
      end else if (!unit_on || (active && sys_ev[iic_master_pkg::EV_STOP])) begin
         byte_cnt_reg <= 8'h00;
      end else if (active && sys_ev[iic_master_pkg::EV_FALL9]) begin
         byte_cnt_reg <= last_byte ? 8'h00 : byte_cnt_reg + 8'h01;
      end
   end

   // Hardware sets win over software clears in the same cycle.
   always_comb begin
      status_next = status_reg;
      if (wr_done && paddr == iic_master_pkg::OFF_CLEAR) begin
         status_next[iic_master_pkg::ST_NACK] =
            status_reg[iic_master_pkg::ST_NACK] & ~pwdata[iic_master_pkg::ST_NACK];
         status_next[iic_master_pkg::ST_STOP] =
            status_reg[iic_master_pkg::ST_STOP] & ~pwdata[iic_master_pkg::ST_STOP];
         status_next[iic_master_pkg::ST_BUS_ERROR_FLAG] =
            status_reg[iic_master_pkg::ST_BUS_ERROR_FLAG] & ~pwdata[iic_master_pkg::ST_BUS_ERROR_FLAG];
         status_next[iic_master_pkg::ST_ARBITRATION_LOST_FLAG] =
            status_reg[iic_master_pkg::ST_ARBITRATION_LOST_FLAG] & ~pwdata[iic_master_pkg::ST_ARBITRATION_LOST_FLAG];
      end
      if (wr_done && paddr == iic_master_pkg::OFF_TXDATA) begin
         status_next[iic_master_pkg::ST_TXE] = 1'b0;
         status_next[iic_master_pkg::ST_TRANSMIT_REQUEST_FLAG] = 1'b0;
      end
      if (rd_done && paddr == iic_master_pkg::OFF_RXDATA) begin
         status_next[iic_master_pkg::ST_RECEIVE_FULL_FLAG] = 1'b0;
      end
      if (wr_done && paddr == iic_master_pkg::OFF_CTRL2) begin
         status_next[iic_master_pkg::ST_TC] = 1'b0;
         status_next[iic_master_pkg::ST_TCR] = 1'b0;
      end
      if (active) begin
         if (sys_ev[iic_master_pkg::EV_FALL8] &&
             ctrl2_reg[iic_master_pkg::CR2_RD_WRN]) begin
            status_next[iic_master_pkg::ST_RECEIVE_FULL_FLAG] = 1'b1;
         end
         if (sys_ev[iic_master_pkg::EV_FALL9]) begin
            status_next[iic_master_pkg::ST_BUSY] = 1'b1;
            if (!ctrl2_reg[iic_master_pkg::CR2_RD_WRN]) begin
               status_next[iic_master_pkg::ST_TXE] = 1'b1;
               if (!(last_byte && !ctrl2_reg[iic_master_pkg::CR2_RELOAD])) begin
                  status_next[iic_master_pkg::ST_TRANSMIT_REQUEST_FLAG] =
                     status_next[iic_master_pkg::ST_TXE];
               end
            end
            if (last_byte && ctrl2_reg[iic_master_pkg::CR2_RELOAD]) begin
               status_next[iic_master_pkg::ST_TCR] = 1'b1;
            end
            if (last_byte && !ctrl2_reg[iic_master_pkg::CR2_RELOAD] &&
                !ctrl2_reg[iic_master_pkg::CR2_AUTOEND]) begin
               status_next[iic_master_pkg::ST_TC] = 1'b1;
            end
         end
         if (sys_ev[iic_master_pkg::EV_NACK]) begin
            status_next[iic_master_pkg::ST_NACK] = 1'b1;
         end
         if (sys_ev[iic_master_pkg::EV_STOP]) begin
            status_next[iic_master_pkg::ST_STOP] = 1'b1;
            status_next[iic_master_pkg::ST_BUSY] = 1'b0;
         end
         if (sys_ev[iic_master_pkg::EV_ARB]) begin
            status_next[iic_master_pkg::ST_ARBITRATION_LOST_FLAG] = 1'b1;
         end
         if (sys_ev[iic_master_pkg::EV_BUS_ERROR_FLAG]) begin
            status_next[iic_master_pkg::ST_BUS_ERROR_FLAG] = 1'b1;
         end
      end
      if (!unit_on) begin
         status_next = 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 16'h0001;
      end else begin
         status_reg <= status_next;
      end
   end

   // ****************************************************************
   // Engine control and interrupt outputs
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_unit_clock_gate <= 1'b0;
         pin_unit_clock_gate <= 1'b0;
         slew_limit_select <= 1'b0;
         alt_pin_select <= 1'b0;
         engine_release <= 1'b1;
         start_request <= 1'b0;
         stop_request <= 1'b0;
         tx_byte <= 8'h00;
      end else begin
         bus_unit_clock_gate <= clkgate_reg[iic_master_pkg::GATE_BUS_UNIT];
         pin_unit_clock_gate <= clkgate_reg[iic_master_pkg::GATE_PIN_UNIT];
         slew_limit_select <= ctrl1_reg[iic_master_pkg::CR1_SLEW];
         alt_pin_select <= pinsel_reg;
         engine_release <= ~unit_on;
         start_request <= ctrl2_reg[iic_master_pkg::CR2_START];
         stop_request <= ctrl2_reg[iic_master_pkg::CR2_STOP];
         tx_byte <= txdata_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <=
            (ctrl1_reg[iic_master_pkg::CR1_ERR_IE] &
             (status_reg[iic_master_pkg::ST_ARBITRATION_LOST_FLAG] |
              status_reg[iic_master_pkg::ST_BUS_ERROR_FLAG])) |
            (ctrl1_reg[iic_master_pkg::CR1_DONE_IE] &
             (status_reg[iic_master_pkg::ST_TC] |
              status_reg[iic_master_pkg::ST_TCR])) |
            (ctrl1_reg[iic_master_pkg::CR1_STOP_IE] &
             status_reg[iic_master_pkg::ST_STOP]) |
            (ctrl1_reg[iic_master_pkg::CR1_NACK_IE] &
             status_reg[iic_master_pkg::ST_NACK]) |
            (ctrl1_reg[iic_master_pkg::CR1_RX_IE] &
             status_reg[iic_master_pkg::ST_RECEIVE_FULL_FLAG]) |
            (ctrl1_reg[iic_master_pkg::CR1_TX_IE] &
             status_reg[iic_master_pkg::ST_TRANSMIT_REQUEST_FLAG]);
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access;
      psel && penable && pready;
   endsequence

   a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup ##1 psel && penable |-> pready)
      else $error("bus answer not after one setup cycle");

   a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && paddr == 8'h20 ##1 s_access |-> pslverr)
      else $error("unmapped address not flagged");

   a_gate_follows: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 bus_unit_clock_gate == $past(clkgate_reg[8]))
      else $error("bus unit gate does not follow register");

   a_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 pin_unit_clock_gate == $past(clkgate_reg[22]))
      else $error("pin unit gate does not follow register");

   a_gate_low_bit: assert property (@(posedge pclk) disable iff (!presetn)
      clkgate_reg[0] && clkgate_reg[31:24] == 8'h00)
      else $error("clock gate fixed bits wrong");

   a_slew_follows: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 slew_limit_select == $past(ctrl1_reg[13]))
      else $error("slew select does not follow control");

   a_ctrl1_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl1_reg & ~32'h0000_20f7) == 32'h0)
      else $error("reserved control bits set");

   a_off_clears: assert property (@(posedge pclk) disable iff (!presetn)
      !unit_on ##1 !unit_on |-> status_reg == 16'h0001 &&
      !ctrl2_reg[13] && !ctrl2_reg[14])
      else $error("flags or requests survive unit off");

   a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl1_reg[7:0] == 8'h00 ##1 ctrl1_reg[7:0] == 8'h00 |-> !irq)
      else $error("interrupt while all enables off");

   a_nack_sets: assert property (@(posedge pclk) disable iff (!presetn)
      active && sys_ev[2] |=> status_reg[4])
      else $error("refused ack flag not raised");

   a_rx_irq: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl1_reg[2] && status_reg[2] |=> irq)
      else $error("receive interrupt missing");
endmodule // iic_master_control_regs
`default_nettype wire

// ==== sim/event_source.sv ====
// Model of the serial engine that raises one event pulse on the link clock.
`timescale 1ns/10ps
`default_nettype none
module event_source (
   // Link clock.
   input wire logic link_clk,
   // Request from the bench: a toggle of go fires one pulse on lane.
   input wire logic go,
   input wire logic [2:0] lane,
   // Event lanes.
   output logic [5:0] ev
);
   logic [2:0] go_sync = 3'h0;
   // Two stages first, so that lane has settled before it is used.
   always @(posedge link_clk) begin
      go_sync <= {go_sync[1:0], go};
      ev <= (go_sync[2] != go_sync[1]) ? (6'h01 << lane) : 6'h00;
   end
endmodule // event_source
`default_nettype wire

// ==== sim/iic_master_control_regs_bench.sv ====
// Testbench of the control registers, driven over APB with link events.
`timescale 1ns/10ps
`default_nettype none
module iic_master_control_regs_bench;
   logic pclk = 1'b0, presetn = 1'b0, link_clk = 1'b0, go = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [7:0] paddr = 8'h00, rx_byte = 8'h3c, tx_byte;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [2:0] lane = 3'h0;
   logic [5:0] ev;
   logic gate_bus, gate_pin, slew, alt, rel, sreq, preq, irq;
   int error_cnt = 0, checks_done = 0;
   int ln[7] = '{2, 3, 4, 5, 0, 1, 1};
   int sb[7] = '{4, 5, 9, 8, 2, 1, 6};
   int ie[7] = '{4, 5, 7, 7, 2, 1, 6};
   logic [31:0] c2[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2400, 32'h22000,
      32'h12000};
   logic [7:0] ca[7] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h14, 8'h18, 8'h04};
   logic [31:0] cd[7] = '{32'h10, 32'h20, 32'h200, 32'h100, 32'h0, 32'ha5,
      32'h0};
   initial forever #12.5 pclk = ~pclk;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   iic_master_control_regs iic_master_control_regs_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_clk(link_clk), .ev_fall8(ev[0]),
      .ev_fall9(ev[1]), .ev_nack(ev[2]), .ev_stop(ev[3]),
      .ev_arb_lost(ev[4]), .ev_bus_error(ev[5]), .rx_byte(rx_byte),
      .bus_unit_clock_gate(gate_bus), .pin_unit_clock_gate(gate_pin),
      .slew_limit_select(slew), .alt_pin_select(alt), .engine_release(rel),
      .start_request(sreq), .stop_request(preq), .tx_byte(tx_byte),
      .irq(irq));
   event_source event_source_inst (.link_clk(link_clk), .go(go),
      .lane(lane), .ev(ev));
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // The request holds until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         end_of_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("register", x, q & m);
   endtask
   // The crossing takes a handful of cycles; twelve leaves margin.
   task automatic fire(input int l);
      lane <= l[2:0];
      go <= ~go;
      repeat (12) @(posedge pclk);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h00, 32'hffffffff, 32'h0);
      rd(8'h40, 32'hffffffff, 32'h1);
      rd(8'h04, 32'hffffffff, 32'h10000000);
      chk("gates", 32'h0, {30'h0, gate_bus, gate_pin});
      $display("Test reset done");
      apb(1'b1, 8'h00, 32'hffffffff);
      rd(8'h00, 32'hffffffff, 32'h20f7);
      chk("slew", 32'h2, {30'h0, slew, rel});
      apb(1'b1, 8'h40, 32'hffffffff);
      rd(8'h40, 32'hffffffff, 32'h00ffff01);
      apb(1'b1, 8'h40, 32'h00400000);
      repeat (2) @(posedge pclk);
      chk("gates", 32'h1, {30'h0, gate_bus, gate_pin});
      apb(1'b1, 8'h00, 32'h1);
      fire(2);
      rd(8'h0c, 32'h10, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      apb(1'b1, 8'h44, 32'h1);
      repeat (2) @(posedge pclk);
      chk("alt pins", 32'h1, {31'h0, alt});
      apb(1'b1, 8'h40, 32'h100);
      $display("Test registers done");
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 8'h04, c2[i]);
         fire(ln[i]);
         rd(8'h0c, 32'h1 << sb[i], 32'h1 << sb[i]);
         chk("irq masked", 32'h0, {31'h0, irq});
         apb(1'b1, 8'h00, 32'h1 | (32'h1 << ie[i]));
         repeat (2) @(posedge pclk);
         chk("irq", 32'h1, {31'h0, irq});
         apb(ca[i] == 8'h14 ? 1'b0 : 1'b1, ca[i], cd[i]);
         if (ca[i] == 8'h14) chk("rx byte", 32'h3c, q & 32'hff);
         repeat (2) @(posedge pclk);
         chk("irq cleared", 32'h0, {31'h0, irq});
         // Switching the unit off and on restarts the byte count.
         apb(1'b1, 8'h00, 32'h0);
         apb(1'b1, 8'h00, 32'h1);
      end
      chk("tx byte", 32'ha5, {24'h0, tx_byte});
      $display("Test flags done");
      apb(1'b1, 8'h04, 32'h6000);
      fire(2);
      chk("requests", 32'h3, {30'h0, sreq, preq});
      apb(1'b1, 8'h00, 32'h2040);
      rd(8'h0c, 32'hffffffff, 32'h1);
      rd(8'h00, 32'hffffffff, 32'h2040);
      chk("release", 32'h9, {28'h0, rel, sreq, preq, slew});
      $display("Test unit off done");
      end_of_test();
   end
endmodule // iic_master_control_regs_bench
`default_nettype wire
